/* File: logic/sacf_device.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Controlword bit 7 clears fault to disabled
// - Held panel key clears drive alarm once clear function is entered
// - Alarm clear input clears active drive alarm
// - Comm alarms clearable, never stored in history
// - Master clears comm alarm before a request to OP
// - Master sets error acknowledge bit 4 at 0x120
// - Fault code reads zero after acknowledge
// - Lost SM2 updates raise 73A
// - Missing SYNC0 pulses raise 73b
// - Excess clock error raises 73c
// - Failed state transition raises 801
// - Failed memory allocation raises 802
// - 801/802 drop operational to safe-operational
// - Out-of-range access raises 803, no change
module sacf_device
   import sacf_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic        I_REF_CLK,          // Drive clock, 40 MHz.
   input  wire logic        I_RST_N,            // Asynchronous reset, active low.
   sacf_if.dev              BUS,                // Slave controller side.
   input  wire logic        I_SM2_UPDATE,       // Pulse per SyncManager2 update.
   input  wire logic        I_SYNC0,            // Distributed clock pulse pin.
   input  wire logic [15:0] I_DC_ERR,           // Clock sync error magnitude.
   input  wire logic [15:0] I_THRESHOLD,        // Alarm threshold in cycles.
   input  wire logic        I_ESM_FAIL,         // Transition failure pulse.
   input  wire logic        I_MEM_FAIL,         // Allocation failure pulse.
   input  wire logic        I_RAM_BOUND,        // Out-of-range access pulse.
   input  wire logic        I_DRIVE_FAULT,      // Drive-side fault pulse.
   input  wire logic        I_PANEL_SEL,        // Panel clear function entered.
   input  wire logic        I_PANEL_KEY,        // Panel key held, raw pin.
   input  wire logic        I_ALARM_CLEAR_INPUT,// Alarm-clear digital input pin.
   input  wire logic [3:0]  I_ESM_REQ,          // Requested fieldbus state.
   input  wire logic        I_ESM_REQ_VLD,      // State request strobe.
   output logic [11:0]      O_ALARM_CODE,       // Active alarm code.
   output logic             O_HIST_WR,          // History record write pulse.
   output logic [11:0]      O_HIST_CODE         // Code written to history.
);
   // Narrower counters could not hold a full threshold value.
   if (CNT_W < 16 || CNT_W > 32) begin : g_cnt_w_check
      $error("CNT_W must be 16..32");
   end

   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic       sync0_d1_q;
   logic [CNT_W-1:0] sm2_cnt_q;
   logic [CNT_W-1:0] sync_cnt_q;
   logic [11:0] alarm_q;
   logic        comm_alarm_q;
   logic        err_ack_q;
   logic [15:0] ctrl_q;
   sacf_esm_e   esm_q;
   sacf_drv_e   drv_q;
   logic        sw_clear;
   logic        comm_evt;
   logic [11:0] comm_code;
   logic        sm2_lost;
   logic        sync_lost;
   logic        dc_bad;
   logic        ack_now;
   logic        fault_rst;
   logic        drv_clr;

   // Pins from outside pass two flip-flops; only stage two is read.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         sync0_d1_q <= 1'b0;
      end else begin
         pin_s1_q <= {I_SYNC0, I_PANEL_KEY, I_ALARM_CLEAR_INPUT};
         pin_s2_q <= pin_s1_q;
         sync0_d1_q <= pin_s2_q[2];
      end
   end

   // Threshold widened so a larger value tolerates longer gaps.
   function automatic logic over_limit(input logic [CNT_W-1:0] cnt,
                                       input logic [15:0] lim);
      over_limit = cnt > CNT_W'(lim);
   endfunction

   assign sm2_lost  = over_limit(sm2_cnt_q, I_THRESHOLD);
   assign sync_lost = over_limit(sync_cnt_q, I_THRESHOLD);
   assign dc_bad    = I_DC_ERR > I_THRESHOLD;

   // Gap counters only run while cyclic data is expected.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sm2_cnt_q  <= '0;
         sync_cnt_q <= '0;
      end else begin
         if (I_SM2_UPDATE || esm_q != ESM_OP) begin
            sm2_cnt_q <= '0;
         end else if (!sm2_lost) begin
            sm2_cnt_q <= sm2_cnt_q + 1'b1;
         end
         if ((pin_s2_q[2] && !sync0_d1_q) || esm_q != ESM_OP) begin
            sync_cnt_q <= '0;
         end else if (!sync_lost) begin
            sync_cnt_q <= sync_cnt_q + 1'b1;
         end
      end
   end

   // Priority among simultaneous comm events: state-affecting ones first.
   always_comb begin
      comm_evt  = 1'b1;
      comm_code = ALM_NONE;
      if (I_ESM_FAIL) begin
         comm_code = ALM_ESM_FAIL;
      end else if (I_MEM_FAIL) begin
         comm_code = ALM_MEM_OVF;
      end else if (I_RAM_BOUND) begin
         comm_code = ALM_RAM_BOUND;
      end else if (sm2_lost) begin
         comm_code = ALM_SM2_LOST;
      end else if (sync_lost && esm_q == ESM_OP) begin
         comm_code = ALM_SYNC0_LOST;
      end else if (dc_bad && esm_q == ESM_OP) begin
         comm_code = ALM_DC_ERROR;
      end else begin
         comm_evt = 1'b0;
      end
   end

   // Panel key only counts once the clear function is entered.
   assign sw_clear = (I_PANEL_SEL && pin_s2_q[1]) || pin_s2_q[0];

   // Slave controller control register; the acknowledge bit is held.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ctrl_q <= 16'h0000;
      end else if (BUS.reg_wr && BUS.reg_addr == LINK_STATE_CONTROL_OFS) begin
         ctrl_q <= BUS.reg_wdata;
      end
   end
   assign err_ack_q = ctrl_q[ERR_ACK_BIT];

   // The acknowledge acts on the edge that writes it, so the next poll reads zero.
   assign ack_now   = err_ack_q || (BUS.reg_wr && BUS.reg_addr == LINK_STATE_CONTROL_OFS
                                    && BUS.reg_wdata[ERR_ACK_BIT]);
   assign fault_rst = BUS.cw_wr && BUS.cw_data[FAULT_RESET_BIT];
   // A drive alarm clears only when no comm alarm is held and no new event arrives.
   assign drv_clr   = !comm_evt && !I_DRIVE_FAULT && !comm_alarm_q && (sw_clear || fault_rst);

   // Alarm holder; a new event wins over any clear in the same cycle.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         alarm_q      <= ALM_NONE;
         comm_alarm_q <= 1'b0;
      end else if (comm_evt) begin
         alarm_q      <= comm_code;
         comm_alarm_q <= 1'b1;
      end else if (I_DRIVE_FAULT) begin
         alarm_q      <= ALM_DRIVE;
         comm_alarm_q <= 1'b0;
      end else if (comm_alarm_q && ack_now) begin
         alarm_q      <= ALM_NONE;
         comm_alarm_q <= 1'b0;
      end else if (drv_clr) begin
         alarm_q      <= ALM_NONE;
      end
   end

   // Only drive alarms reach the history; comm alarms are never recorded.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_HIST_WR   <= 1'b0;
         O_HIST_CODE <= ALM_NONE;
      end else begin
         O_HIST_WR <= I_DRIVE_FAULT && !comm_evt;
         if (I_DRIVE_FAULT && !comm_evt) begin
            O_HIST_CODE <= ALM_DRIVE;
         end
      end
   end

   // Fieldbus state: 801/802 pull OP back to SAFEOP, 803 changes nothing.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         esm_q <= ESM_INIT;
      end else if ((I_ESM_FAIL || I_MEM_FAIL) && esm_q == ESM_OP) begin
         esm_q <= ESM_SAFEOP;
      end else if (I_ESM_FAIL || I_MEM_FAIL) begin
         esm_q <= esm_q;
      end else if (I_ESM_REQ_VLD && !(comm_alarm_q && I_ESM_REQ == ESM_OP)) begin
         unique case (I_ESM_REQ)
            ESM_INIT, ESM_PREOP, ESM_BOOT, ESM_SAFEOP, ESM_OP: esm_q <= sacf_esm_e'(I_ESM_REQ);
            default: esm_q <= esm_q;
         endcase
      end
   end

   // Drive profile state: fault while any alarm, reset via controlword.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         drv_q <= DRV_SOD;
      end else if (alarm_q != ALM_NONE && !drv_clr) begin
         drv_q <= DRV_FAULT;
      end else if (drv_q == DRV_FAULT && fault_rst) begin
         drv_q <= DRV_SOD;
      end else if (drv_q == DRV_SOD && BUS.cw_wr && BUS.cw_data[3:0] == 4'hf) begin
         drv_q <= DRV_ON;
      end
   end

   // Register read port; fault code reads zero once acknowledged.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         BUS.reg_rdata  <= 16'h0000;
         BUS.reg_rvalid <= 1'b0;
      end else begin
         BUS.reg_rvalid <= BUS.reg_rd;
         if (BUS.reg_rd && BUS.reg_addr == LINK_FAULT_CODE_OFS) begin
            BUS.reg_rdata <= comm_alarm_q ? {4'h0, alarm_q} : 16'h0000;
         end else if (BUS.reg_rd && BUS.reg_addr == LINK_STATE_CONTROL_OFS) begin
            BUS.reg_rdata <= ctrl_q;
         end else if (BUS.reg_rd) begin
            BUS.reg_rdata <= 16'h0000;
         end
      end
   end

   assign BUS.esm_state = esm_q;
   assign BUS.drv_state = drv_q;
   assign O_ALARM_CODE  = alarm_q;
endmodule
`default_nettype wire

/* File: inc/sacf_pkg.sv */
package sacf_pkg;
   // Slave controller register offsets, byte addresses.
   localparam logic [15:0] LINK_STATE_CONTROL_OFS = 16'h0120;
   localparam logic [15:0] LINK_FAULT_CODE_OFS    = 16'h0134;
   // Field positions.
   localparam int ERR_ACK_BIT     = 4;
   localparam int FAULT_RESET_BIT = 7;
   localparam logic [15:0] CTRLWORD_INDEX = 16'h6040;
   // Alarm codes, main and sub digit packed as shown on the panel.
   localparam logic [11:0] ALM_NONE       = 12'h000;
   localparam logic [11:0] ALM_SM2_LOST   = 12'h73a;
   localparam logic [11:0] ALM_SYNC0_LOST = 12'h73b;
   localparam logic [11:0] ALM_DC_ERROR   = 12'h73c;
   localparam logic [11:0] ALM_ESM_FAIL   = 12'h801;
   localparam logic [11:0] ALM_MEM_OVF    = 12'h802;
   localparam logic [11:0] ALM_RAM_BOUND  = 12'h803;
   localparam logic [11:0] ALM_DRIVE      = 12'h100;
   localparam logic [15:0] THRESH_RESET   = 16'h0010;
   // Fieldbus state machine states.
   typedef enum logic [3:0] {
      ESM_INIT   = 4'h1,
      ESM_PREOP  = 4'h2,
      ESM_BOOT   = 4'h3,
      ESM_SAFEOP = 4'h4,
      ESM_OP     = 4'h8
   } sacf_esm_e;
   // Drive profile state machine states (reduced).
   typedef enum logic [1:0] {
      DRV_SOD   = 2'b00,
      DRV_ON    = 2'b01,
      DRV_FAULT = 2'b10
   } sacf_drv_e;
endpackage

/* File: inc/sacf_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Register port of the slave controller plus the controlword path.
interface sacf_if;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic        cw_wr;
   logic [15:0] cw_data;
   logic [3:0]  esm_state;
   logic [1:0]  drv_state;
   modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, cw_wr, cw_data,
                output reg_rdata, reg_rvalid, esm_state, drv_state);
   modport mst (output reg_wr, reg_rd, reg_addr, reg_wdata, cw_wr, cw_data,
                input reg_rdata, reg_rvalid, esm_state, drv_state);
endinterface
`default_nettype wire

/* File: logic/sacf_master.sv */
`timescale 1ns/1ps
`default_nettype none
// Master end: acknowledges comm alarms, then issues the fault reset.
module sacf_master
   import sacf_pkg::*;
(
   input  wire logic        I_REF_CLK,     // Drive clock, 40 MHz.
   input  wire logic        I_RST_N,       // Asynchronous reset, active low.
   sacf_if.mst              BUS,           // Master side.
   input  wire logic        I_CLEAR_REQ,   // Start a clear sequence, pulse.
   output logic             O_BUSY,        // Sequence running.
   output logic             O_DONE         // Sequence finished, pulse.
);
   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_ACK  = 3'b001,
      M_POLL = 3'b010,
      M_WAIT = 3'b011,
      M_RST  = 3'b100,
      M_UNACK = 3'b101
   } sacf_mst_e;
   sacf_mst_e st_q;

   // Sequence: ack bit set, poll code to zero, fault reset, ack bit released.
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_q <= M_IDLE;
      end else begin
         unique case (st_q)
            M_IDLE:  if (I_CLEAR_REQ) st_q <= M_ACK;
            M_ACK:   st_q <= M_POLL;
            M_POLL:  st_q <= M_WAIT;
            M_WAIT:  if (BUS.reg_rvalid) st_q <= (BUS.reg_rdata == 16'h0000) ? M_RST : M_POLL;
            M_RST:   st_q <= M_UNACK;
            M_UNACK: st_q <= M_IDLE;
            default: st_q <= M_IDLE;
         endcase
      end
   end

   // Bus strobes are decoded from the state.
   always_comb begin
      BUS.reg_wr    = st_q == M_ACK || st_q == M_UNACK;
      BUS.reg_rd    = st_q == M_POLL;
      BUS.reg_addr  = (st_q == M_POLL || st_q == M_WAIT) ? LINK_FAULT_CODE_OFS
                                                          : LINK_STATE_CONTROL_OFS;
      BUS.reg_wdata = (st_q == M_ACK) ? 16'(1 << ERR_ACK_BIT) : 16'h0000;
      BUS.cw_wr     = st_q == M_RST;
      BUS.cw_data   = (st_q == M_RST) ? 16'(1 << FAULT_RESET_BIT) : 16'h0000;
   end

   assign O_BUSY = st_q != M_IDLE;
   assign O_DONE = st_q == M_UNACK;
endmodule
`default_nettype wire

/* File: sim/sacf_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and controlword path between master and device.
module sacf_props
   import sacf_pkg::*;
(
   input wire logic        I_REF_CLK,  // Drive clock.
   input wire logic        I_RST_N,    // Reset, active low.
   input wire logic        reg_wr,     // Register write strobe.
   input wire logic        reg_rd,     // Register read strobe.
   input wire logic [15:0] reg_addr,   // Register byte address.
   input wire logic [15:0] reg_wdata,  // Register write data.
   input wire logic [15:0] reg_rdata,  // Register read data.
   input wire logic        reg_rvalid, // Read answer strobe.
   input wire logic        cw_wr,      // Controlword write strobe.
   input wire logic [15:0] cw_data,    // Controlword value.
   input wire logic [3:0]  esm_state,  // Fieldbus state.
   input wire logic [1:0]  drv_state   // Drive profile state.
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   // The acknowledge write and the status poll that the master issues after it.
   sequence seq_ack;
      reg_wr && reg_addr == LINK_STATE_CONTROL_OFS && reg_wdata[ERR_ACK_BIT];
   endsequence
   sequence seq_poll;
      reg_rd && reg_addr == LINK_FAULT_CODE_OFS;
   endsequence
   sequence seq_zero;
      reg_rvalid && reg_rdata == 16'h0000;
   endsequence
   AST_READ_ANSWER: assert property (seq_poll |=> reg_rvalid)
      else $error("read of fault code got no answer");
   AST_ACK_CLEARS_CODE: assert property (seq_ack ##1 seq_poll |=> seq_zero)
      else $error("fault code not zero after acknowledge");
   AST_CW_NEEDS_ZERO: assert property (cw_wr |-> $past(reg_rvalid) && $past(reg_rdata) == 16'h0000)
      else $error("fault reset issued without a zero fault code");
   AST_CW_AFTER_ACK: assert property (seq_ack ##1 seq_poll ##1 seq_zero |=> cw_wr && cw_data[FAULT_RESET_BIT])
      else $error("fault reset missing after zero fault code");
   AST_ACK_RELEASE: assert property (cw_wr |=> reg_wr && reg_addr == LINK_STATE_CONTROL_OFS && !reg_wdata[ERR_ACK_BIT])
      else $error("acknowledge bit not released after fault reset");
   AST_FAULT_TO_SOD: assert property (cw_wr && cw_data[FAULT_RESET_BIT] && drv_state == DRV_FAULT |-> ##[1:2] drv_state == DRV_SOD)
      else $error("drive did not leave fault on fault reset");
   AST_RESET_STATE: assert property ($rose(I_RST_N) |-> esm_state == ESM_INIT && drv_state == DRV_SOD)
      else $error("states wrong after reset");
   AST_RDATA_HOLD: assert property (!reg_rvalid |-> $stable(reg_rdata))
      else $error("read data changed without an answer");
endmodule
`default_nettype wire

/* File: sim/servo_alarm_clear_and_comm_faults_test.sv */
`timescale 1ns/1ps
`default_nettype none
module servo_alarm_clear_and_comm_faults_test;
   import sacf_pkg::*;
   logic        I_REF_CLK = 1'b0;
   logic        I_RST_N = 1'b0;
   logic        I_SM2_UPDATE = 1'b0, I_SYNC0 = 1'b0, I_ESM_FAIL = 1'b0, I_MEM_FAIL = 1'b0;
   logic        I_RAM_BOUND = 1'b0, I_DRIVE_FAULT = 1'b0, I_PANEL_SEL = 1'b0, I_PANEL_KEY = 1'b0;
   logic        I_ALARM_CLEAR_INPUT = 1'b0, I_ESM_REQ_VLD = 1'b0, I_CLEAR_REQ = 1'b0;
   logic [15:0] I_DC_ERR = 16'h0000, I_THRESHOLD = 16'h0006;
   logic [3:0]  I_ESM_REQ = 4'h1;
   logic [11:0] O_ALARM_CODE, O_HIST_CODE;
   logic        O_HIST_WR, O_BUSY, O_DONE;
   logic        sm2_en = 1'b1, sync_en = 1'b1;
   int          error_cnt = 0, n_compared = 0, hist_cnt = 0;
   sacf_if bus ();
   sacf_device #(.CNT_W(16)) u_sacf_device (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .BUS(bus),
      .I_SM2_UPDATE(I_SM2_UPDATE), .I_SYNC0(I_SYNC0), .I_DC_ERR(I_DC_ERR),
      .I_THRESHOLD(I_THRESHOLD), .I_ESM_FAIL(I_ESM_FAIL), .I_MEM_FAIL(I_MEM_FAIL),
      .I_RAM_BOUND(I_RAM_BOUND), .I_DRIVE_FAULT(I_DRIVE_FAULT), .I_PANEL_SEL(I_PANEL_SEL),
      .I_PANEL_KEY(I_PANEL_KEY), .I_ALARM_CLEAR_INPUT(I_ALARM_CLEAR_INPUT),
      .I_ESM_REQ(I_ESM_REQ), .I_ESM_REQ_VLD(I_ESM_REQ_VLD), .O_ALARM_CODE(O_ALARM_CODE),
      .O_HIST_WR(O_HIST_WR), .O_HIST_CODE(O_HIST_CODE));
   sacf_master u_sacf_master (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .BUS(bus),
      .I_CLEAR_REQ(I_CLEAR_REQ), .O_BUSY(O_BUSY), .O_DONE(O_DONE));
   sacf_props u_sacf_props (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .reg_wr(bus.reg_wr),
      .reg_rd(bus.reg_rd), .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
      .reg_rdata(bus.reg_rdata), .reg_rvalid(bus.reg_rvalid), .cw_wr(bus.cw_wr),
      .cw_data(bus.cw_data), .esm_state(bus.esm_state), .drv_state(bus.drv_state));
   always #12.5 I_REF_CLK = ~I_REF_CLK;
   // Sync manager and SYNC0 pulses every second cycle, well inside the threshold.
   always @(negedge I_REF_CLK) begin
      I_SM2_UPDATE <= sm2_en & ~I_SM2_UPDATE;
      I_SYNC0      <= sync_en & ~I_SYNC0;
   end
   // Counts history writes, so comm alarms can be shown to leave no record.
   always @(negedge I_REF_CLK) begin
      if (O_HIST_WR === 1'b1) hist_cnt <= hist_cnt + 1;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge I_REF_CLK);
   endtask
   task automatic pulse(ref logic sig);
      sig = 1'b1;
      cycles(1);
      sig = 1'b0;
   endtask
   // Bounded wait; a code that never shows ends the run at once.
   task automatic wait_code(input logic [11:0] exp, input int n);
      for (int i = 0; i < n && O_ALARM_CODE !== exp; i++) cycles(1);
      check("alarm code", {4'h0, O_ALARM_CODE}, {4'h0, exp});
      if (O_ALARM_CODE !== exp) close_out();
   endtask
   task automatic master_clear();
      pulse(I_CLEAR_REQ);
      check("busy", {15'h0, O_BUSY}, 16'h0001);
      for (int i = 0; i < 40 && O_DONE !== 1'b1; i++) cycles(1);
      check("clear done", {15'h0, O_DONE}, 16'h0001);
      if (O_DONE !== 1'b1) close_out();
      cycles(3);
      check("alarm after clear", {4'h0, O_ALARM_CODE}, 16'h0000);
      check("idle after clear", {15'h0, O_BUSY}, 16'h0000);
   endtask
   task automatic esm_go(input logic [3:0] st);
      I_ESM_REQ = st;
      pulse(I_ESM_REQ_VLD);
      cycles(2);
      check("esm state", {12'h0, bus.esm_state}, {12'h0, st});
   endtask
   task automatic t_loss();
      esm_go(ESM_PREOP);
      esm_go(ESM_SAFEOP);
      esm_go(ESM_OP);
      I_THRESHOLD = 16'h0028;
      sm2_en = 1'b0;
      cycles(20);
      check("raised threshold", {4'h0, O_ALARM_CODE}, 16'h0000);
      I_THRESHOLD = 16'h0006;
      wait_code(ALM_SM2_LOST, 20);
      sm2_en = 1'b1;
      cycles(6);
      master_clear();
      sync_en = 1'b0;
      wait_code(ALM_SYNC0_LOST, 20);
      sync_en = 1'b1;
      cycles(6);
      master_clear();
      I_DC_ERR = 16'h0007;
      wait_code(ALM_DC_ERROR, 20);
      I_DC_ERR = 16'h0000;
      master_clear();
      $display("loss test done");
   endtask
   task automatic t_fail();
      esm_go(ESM_OP);
      pulse(I_ESM_FAIL);
      wait_code(ALM_ESM_FAIL, 5);
      check("esm after 801", {12'h0, bus.esm_state}, {12'h0, ESM_SAFEOP});
      master_clear();
      pulse(I_MEM_FAIL);
      wait_code(ALM_MEM_OVF, 5);
      check("esm after 802", {12'h0, bus.esm_state}, {12'h0, ESM_SAFEOP});
      master_clear();
      pulse(I_RAM_BOUND);
      wait_code(ALM_RAM_BOUND, 5);
      check("esm after 803", {12'h0, bus.esm_state}, {12'h0, ESM_SAFEOP});
      master_clear();
      check("history writes", 16'(hist_cnt), 16'h0000);
      $display("failure test done");
   endtask
   task automatic t_drive();
      pulse(I_DRIVE_FAULT);
      wait_code(ALM_DRIVE, 5);
      check("history code", {4'h0, O_HIST_CODE}, {4'h0, ALM_DRIVE});
      I_PANEL_KEY = 1'b1;
      cycles(6);
      check("key without select", {4'h0, O_ALARM_CODE}, {4'h0, ALM_DRIVE});
      I_PANEL_SEL = 1'b1;
      wait_code(ALM_NONE, 6);
      I_PANEL_KEY = 1'b0;
      I_PANEL_SEL = 1'b0;
      pulse(I_DRIVE_FAULT);
      wait_code(ALM_DRIVE, 5);
      I_ALARM_CLEAR_INPUT = 1'b1;
      wait_code(ALM_NONE, 6);
      I_ALARM_CLEAR_INPUT = 1'b0;
      cycles(4);
      pulse(I_DRIVE_FAULT);
      wait_code(ALM_DRIVE, 5);
      master_clear();
      check("drive state", {14'h0, bus.drv_state}, {14'h0, DRV_SOD});
      check("history writes", 16'(hist_cnt), 16'h0003);
      $display("drive test done");
   endtask
   // Reset for two cycles, then the scenarios in turn.
   initial begin
      cycles(2);
      I_RST_N = 1'b1;
      cycles(1);
      check("alarm at reset", {4'h0, O_ALARM_CODE}, 16'h0000);
      check("esm at reset", {12'h0, bus.esm_state}, {12'h0, ESM_INIT});
      t_loss();
      t_fail();
      t_drive();
      close_out();
   end
endmodule
`default_nettype wire
